/* pkg/refdet_pkg.sv */
// package for the reference detect diagnostics block
// assumes one 25 MHz clock and a word-addressed Avalon-MM slave
package refdet_pkg;
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFF_DIAG_EN = 4'h0;
    localparam logic [3:0] OFF_ERROR = 4'h1;
    localparam logic [3:0] OFF_STATUS = 4'h2;
    localparam logic [3:0] OFF_CONFIG = 4'h3;
    localparam logic [3:0] OFF_RESULT = 4'h4;
    localparam logic [3:0] OFF_COEF_OFS = 4'h5;
    localparam logic [3:0] OFF_COEF_GAIN = 4'h6;
    localparam logic [3:0] OFF_IRQ_STAT = 4'h7;
    localparam logic [3:0] OFF_IRQ_EN = 4'h8;
    localparam logic [3:0] OFF_IRQ_CLR = 4'h9;
    localparam int BIT_REF_CHECK_EN = 0;
    localparam int BIT_REF_EXT = 0;
    localparam int BIT_TEST_SEL = 1;
    localparam int BIT_STATUS_ERR = 0;
    localparam int BIT_STATUS_REF_OK = 1;
    localparam int BIT_STATUS_TEST = 2;
    localparam int IRQ_N = 3;
    localparam int IRQ_REF_MISS = 0;
    localparam int IRQ_CAL_BLOCK = 1;
    localparam int IRQ_RESULT = 2;
    localparam logic [31:0] RESET_DIAG_EN = 32'h0000_0000;
    localparam logic [31:0] RESET_CONFIG = 32'h0000_0000;
    localparam logic [23:0] RESET_COEF_OFS = 24'h80_0000;
    localparam logic [23:0] RESET_COEF_GAIN = 24'h50_0000;
    localparam logic [23:0] RESULT_ALL_ONES = 24'hFF_FFFF;
    localparam int REF_MIN_MV = 700;
    localparam int TEST_SIG_MV = 20;
    localparam int TEST_CM_MV = 10;

    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [31:0] writedata;
    } avmm_req_t;

    typedef struct packed {
        logic valid;
        logic [23:0] data;
    } result_t;

    typedef struct packed {
        logic done;
        logic is_gain;
        logic [23:0] coef;
    } cal_t;
endpackage

/* rtl/reference_detect_diagnostics.sv */
// reference detect diagnostics: flag, result forcing, calibration guard, test signal select
// assumes analog comparators deliver levels synchronous to clk; Avalon-MM master on one clock
//
// Contract
// - detect only while reference_check_enable is 1
// - detect only with external reference selected
// - low or open reference sets reference_missing_flag
// - flag set also sets summary error bit
// - flag forces conversion results to all ones
// - flag blocks calibration coefficient write
// - flag may set on standby exit
// - error register read clears the flag
// - test signal pair routes internal 20 mV
//
// The Avalon-MM register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module reference_detect_diagnostics
    import refdet_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire avmm_req_t avs_req,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic ref_below_min,
    input wire logic ref_input_open,
    input wire logic standby_exit,
    input wire result_t conv_in,
    input wire cal_t cal_in,
    output result_t conv_out,
    output logic test_signal_positive,
    output logic test_signal_negative,
    output logic irq
);
    logic ack_r;
    logic [31:0] diag_en_r;
    logic [31:0] config_r;
    logic flag_r;
    logic [23:0] coef_ofs_r;
    logic [23:0] coef_gain_r;
    logic [23:0] last_result_r;
    logic [IRQ_N-1:0] irq_stat_r;
    logic [IRQ_N-1:0] irq_en_r;
    logic [31:0] rdata_nxt;
    logic access;
    logic wr_hit;
    logic rd_err;
    logic detect_on;
    logic ref_bad;
    logic cal_blocked;
    logic [IRQ_N-1:0] irq_event;

    // one wait state per access: ack pulses, waitrequest drops with it
    assign access = (avs_req.read | avs_req.write) & ~ack_r;
    assign wr_hit = avs_req.write & ~ack_r;
    assign rd_err = avs_req.read & ~ack_r & (avs_req.address == OFF_ERROR);
    assign detect_on = diag_en_r[BIT_REF_CHECK_EN]
        & config_r[BIT_REF_EXT];
    assign ref_bad = detect_on & (ref_below_min | ref_input_open);
    // standby exit may glitch the detector, modelled as a set
    assign cal_blocked = cal_in.done & (flag_r | ref_bad);
    assign irq_event[IRQ_REF_MISS] = ref_bad | (standby_exit & detect_on);
    assign irq_event[IRQ_CAL_BLOCK] = cal_blocked;
    assign irq_event[IRQ_RESULT] = conv_in.valid;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= access;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= ~access;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            diag_en_r <= RESET_DIAG_EN;
            config_r <= RESET_CONFIG;
            irq_en_r <= '0;
        end else if (wr_hit) begin
            case (avs_req.address)
                OFF_DIAG_EN: diag_en_r <= {31'h0, avs_req.writedata[BIT_REF_CHECK_EN]};
                OFF_CONFIG: config_r <= {30'h0, avs_req.writedata[1:0]};
                OFF_IRQ_EN: irq_en_r <= avs_req.writedata[IRQ_N-1:0];
                default: ;
            endcase
        end
    end

    // set wins over a same-cycle clearing read
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flag_r <= 1'b0;
        end else if (ref_bad | (standby_exit & detect_on)) begin
            flag_r <= 1'b1;
        end else if (rd_err) begin
            flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            coef_ofs_r <= RESET_COEF_OFS;
            coef_gain_r <= RESET_COEF_GAIN;
        end else if (cal_in.done & ~cal_blocked) begin
            if (cal_in.is_gain) begin
                coef_gain_r <= cal_in.coef;
            end else begin
                coef_ofs_r <= cal_in.coef;
            end
        end
    end

    // forcing uses the live condition too, so the first bad result is caught
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            conv_out <= '0;
            last_result_r <= '0;
        end else begin
            conv_out.valid <= conv_in.valid;
            if (conv_in.valid) begin
                conv_out.data <= (flag_r | ref_bad) ? RESULT_ALL_ONES : conv_in.data;
                last_result_r <= (flag_r | ref_bad) ? RESULT_ALL_ONES : conv_in.data;
            end
        end
    end

    // test pair selection steers the internal 20 mV source
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            test_signal_positive <= 1'b0;
            test_signal_negative <= 1'b0;
        end else begin
            test_signal_positive <= config_r[BIT_TEST_SEL];
            test_signal_negative <= config_r[BIT_TEST_SEL];
        end
    end

    genvar i;
    generate
        for (i = 0; i < IRQ_N; i++) begin : g_irq
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    irq_stat_r[i] <= 1'b0;
                end else if (irq_event[i]) begin
                    irq_stat_r[i] <= 1'b1;
                end else if (wr_hit & (avs_req.address == OFF_IRQ_CLR) & avs_req.writedata[i]) begin
                    irq_stat_r[i] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_r & irq_en_r);
        end
    end

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (avs_req.address)
            OFF_DIAG_EN: rdata_nxt = diag_en_r;
            OFF_ERROR: rdata_nxt = {31'h0, flag_r};
            OFF_STATUS: rdata_nxt = {29'h0, config_r[BIT_TEST_SEL], ~flag_r, flag_r};
            OFF_CONFIG: rdata_nxt = config_r;
            OFF_RESULT: rdata_nxt = {8'h00, last_result_r};
            OFF_COEF_OFS: rdata_nxt = {8'h00, coef_ofs_r};
            OFF_COEF_GAIN: rdata_nxt = {8'h00, coef_gain_r};
            OFF_IRQ_STAT: rdata_nxt = {29'h0, irq_stat_r};
            OFF_IRQ_EN: rdata_nxt = {29'h0, irq_en_r};
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (access) begin
            avs_readdata <= rdata_nxt;
        end
    end
endmodule

/* tb/refdet_checker.sv */
// assertions on the ports of reference_detect_diagnostics
// assumes one clock and an async active-low reset
`timescale 1ns/1ps
module refdet_checker
    import refdet_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire avmm_req_t avs_req,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic ref_below_min,
    input wire logic ref_input_open,
    input wire logic standby_exit,
    input wire result_t conv_in,
    input wire cal_t cal_in,
    input wire result_t conv_out,
    input wire logic test_signal_positive,
    input wire logic test_signal_negative,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire rq = avs_req.read | avs_req.write;
    // any cause that may raise irq: an interrupt status event or a register write
    wire ev = avs_req.write | conv_in.valid | cal_in.done | standby_exit | ref_below_min | ref_input_open;
    sequence s_take;
        rq && avs_waitrequest;
    endsequence
    sequence s_ack;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    a_single_wait: assert property (s_take |=> s_ack) else $error("access not one wait state");
    a_ack_cause: assert property ($fell(avs_waitrequest) |-> $past(rq)) else $error("ack without request");
    a_rdata_hold: assert property (avs_waitrequest && $past(avs_waitrequest) |-> $stable(avs_readdata))
        else $error("read data moved while idle");
    a_conv_latency: assert property (conv_in.valid |=> conv_out.valid) else $error("result late");
    a_conv_data: assert property (conv_in.valid |=> conv_out.data == $past(conv_in.data)
        || conv_out.data == RESULT_ALL_ONES) else $error("result corrupted");
    a_test_pair: assert property (test_signal_positive == test_signal_negative) else $error("test pair split");
    a_irq_cause: assert property ($rose(irq) |-> $past(ev) || $past(ev, 2) || $past(ev, 3))
        else $error("irq without event");
    a_irq_fall: assert property ($fell(irq) |-> $past(avs_req.write) || $past(avs_req.write, 2))
        else $error("irq dropped without write");
endmodule
bind reference_detect_diagnostics refdet_checker i_refdet_checker (.*);

/* tb/tb.sv */
// self-checking bench for reference_detect_diagnostics
// assumes one wait state per access and one cycle result latency
`timescale 1ns/1ps
module tb
    import refdet_pkg::*;
;
    logic clk = 0, reset_n = 0, lo = 0, op = 0, sb = 0, tsp, tsn, irq, wt;
    avmm_req_t req = '0;
    result_t cin = '0, cout;
    cal_t cal = '0;
    logic [31:0] rdata, rv;
    int errors = 0, samples_checked = 0;
    always #20 clk = ~clk;
    reference_detect_diagnostics i_reference_detect_diagnostics (.clk(clk), .reset_n(reset_n),
        .avs_req(req), .avs_readdata(rdata), .avs_waitrequest(wt), .ref_below_min(lo), .ref_input_open(op),
        .standby_exit(sb), .conv_in(cin), .cal_in(cal), .conv_out(cout),
        .test_signal_positive(tsp), .test_signal_negative(tsn), .irq(irq));
    task report_and_stop;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(input logic [31:0] g, e);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    // one edge after release so back-to-back calls never drive req twice
    task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        req <= '{~w, w, a, d};
        do begin
            @(posedge clk);
            n++;
        end while (wt !== 1'b0 && n < 20);
        rv = rdata;
        req <= '0;
        @(posedge clk);
        if (n >= 20) begin
            errors++;
            report_and_stop;
        end
    endtask
    task rd(input logic [3:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk(rv, e);
    endtask
    task cv(input logic [23:0] d, e);
        cin <= '{1'b1, d};
        @(posedge clk);
        cin <= '0;
        @(posedge clk);
        chk({8'h00, cout.data}, {8'h00, e});
    endtask
    task cl(input logic g, input logic [23:0] c);
        cal <= '{1'b1, g, c};
        @(posedge clk);
        cal <= '0;
        @(posedge clk);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rd(OFF_DIAG_EN, RESET_DIAG_EN);
        rd(OFF_CONFIG, RESET_CONFIG);
        rd(4'hF, 32'h0);
        lo <= 1'b1;
        acc(1'b1, OFF_CONFIG, 32'h1);
        rd(OFF_ERROR, 32'h0);
        cv(24'h123456, 24'h123456);
        acc(1'b1, OFF_CONFIG, 32'h0);
        acc(1'b1, OFF_DIAG_EN, 32'h1);
        rd(OFF_ERROR, 32'h0);
        acc(1'b1, OFF_IRQ_EN, 32'h1);
        acc(1'b1, OFF_CONFIG, 32'h1);
        for (int i = 0; i < 2; i++) begin
            {lo, op} <= i ? 2'b01 : 2'b10;
            @(posedge clk);
            rd(OFF_STATUS, 32'h1);
            cl(i == 0, 24'h123);
            {lo, op} <= 2'b00;
            cv(24'h0, RESULT_ALL_ONES);
            rd(OFF_ERROR, 32'h1);
            rd(OFF_ERROR, 32'h0);
            cv(24'hABCDEF, 24'hABCDEF);
        end
        rd(OFF_COEF_GAIN, {8'h00, RESET_COEF_GAIN});
        rd(OFF_COEF_OFS, {8'h00, RESET_COEF_OFS});
        cl(1'b0, 24'h654321);
        rd(OFF_COEF_OFS, 32'h654321);
        chk({31'h0, irq}, 32'h1);
        rd(OFF_IRQ_STAT, 32'h7);
        acc(1'b1, OFF_IRQ_EN, 32'h0);
        chk({31'h0, irq}, 32'h0);
        acc(1'b1, OFF_IRQ_EN, 32'h1);
        acc(1'b1, OFF_IRQ_CLR, 32'h7);
        chk({31'h0, irq}, 32'h0);
        acc(1'b1, OFF_STATUS, 32'hFFFFFFFF);
        acc(1'b1, OFF_CONFIG, 32'h3);
        chk({30'h0, tsp, tsn}, 32'h3);
        rd(OFF_STATUS, 32'h6);
        sb <= 1'b1;
        @(posedge clk);
        sb <= 1'b0;
        rd(OFF_ERROR, 32'h1);
        rd(OFF_ERROR, 32'h0);
        report_and_stop;
    end
endmodule
